// ===== dv/bcrf_rt_model.sv
// Remote terminal model answering each command with a status word unless silent_in holds it silent
`default_nettype none
module bcrf_rt_model
(
    input wire logic clk_in,
    input wire logic [5:0] cmd_addr_in,
    input wire logic [9:0] sts_bits_in,
    input wire logic addr_fault_in,
    input wire logic silent_in,
    output logic [15:0] status_word_out,
    output logic status_valid_out,
    output logic no_response_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] last_word = 16'h0000;
    logic [15:0] reply;
    // Wrong address only when the bench commands it
    assign reply = {cmd_addr_in ^ {5'h00, addr_fault_in}, sts_bits_in};
    always_ff @(posedge clk_in)
    begin
        if (!silent_in)
        begin
            last_word <= reply;
        end
    end
    // Released line shows the inverse, so a stale word cannot pass as valid
    assign status_word_out = silent_in ? ~last_word : reply;
    assign status_valid_out = ~silent_in;
    assign no_response_out = silent_in;
endmodule : bcrf_rt_model
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the message result flags
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic msg_done = 1'b0;
    logic [2:0] mtype = 3'h0;
    logic [15:0] cw = 16'hFFFF;
    logic [9:0] sb = 10'h000;
    logic [5:0] cmd = 6'h00;
    logic af = 1'b0, sl = 1'b0, we = 1'b0, rx = 1'b0, lb = 1'b0, be = 1'b0;
    logic [15:0] sw;
    logic sv, nr, f_m, f_g, f_f, f_b, f_e, done_q = 1'b0, clr_q = 1'b0, armed = 1'b0;
    logic [4:0] cur = 5'h00;
    logic [4:0] note_q[$];
    logic [31:0] r = 32'h386E;
    logic [31:0] q = 32'h0000_0000;
    int error_cnt = 0, check_count = 0, cyc = 0;
    initial forever #10 clk_in = ~clk_in;
    bcrf_rt_model rt (.clk_in(clk_in), .cmd_addr_in(cmd), .sts_bits_in(sb), .addr_fault_in(af),
        .silent_in(sl), .status_word_out(sw), .status_valid_out(sv), .no_response_out(nr));
    bcrf_result_flags DUT (.clk_in(clk_in), .rst_in(rst_in), .msg_done_in(msg_done),
        .msg_type_in(mtype), .control_word_in(cw), .status_word_in(sw), .status_valid_in(sv),
        .cmd_addr_in(cmd), .bcr_mask_enable_in(be), .word_error_in(we),
        .rx_portion_error_in(rx), .no_response_in(nr), .loopback_fail_in(lb),
        .masked_status_flag_out(f_m), .good_transfer_flag_out(f_g),
        .format_error_flag_out(f_f), .bad_message_flag_out(f_b), .error_flag_out(f_e));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction : lfsr
    task automatic complete_run();
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic check(input logic seen, input logic want);
        check_count++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("[FAIL] %0t flag %b expected %b", $time, seen, want);
        end
    endtask : check
    // Expected flags {masked, good, format, bad, error} from the current stimulus
    function automatic logic [4:0] want_flags();
        logic [15:0] w;
        logic m, am, f, b, g;
        w = {cmd ^ {5'h00, af}, sb};
        m = !sl && ((|(w[14:9] & ~cw[14:9])) || (!cw[9] && (|w[7:5])) || (be && (cw[0] ^ w[4])));
        am = !sl && af;
        f = we || rx || am;
        b = f || lb || sl;
        g = (mtype == bcrf_pkg::MSG_RT_TO_BC || mtype == bcrf_pkg::MSG_RT_TO_RT
            || mtype == bcrf_pkg::MSG_MODE_TX_DATA) && !we && !am && !sl;
        return {m, g, f, b, b};
    endfunction : want_flags
    // Leaves msg_done high so the caller may follow back to back
    // All message inputs but msg_done change only here, after the edge that took the last one
    task automatic send(input logic [2:0] t, input logic [15:0] c, input logic [9:0] s,
        input logic [5:0] e, input logic [5:0] a);
        @(negedge clk_in);
        {mtype, cw, sb} = {t, c, s};
        {af, sl, we, rx, lb, be} = e;
        cmd = a;
        msg_done = 1'b1;
        note_q.push_back(want_flags());
    endtask : send
    task automatic idle();
        @(negedge clk_in);
        msg_done = 1'b0;
    endtask : idle
    always @(posedge clk_in)
    begin
        done_q <= msg_done && !rst_in;
        clr_q <= rst_in;
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    always @(negedge clk_in)
    begin
        if (clr_q)
            {armed, cur} = {1'b1, 5'h00};
        else if (done_q)
            cur = note_q.pop_front();
        if (armed)
        begin
            check(f_m, cur[4]);
            check(f_g, cur[3]);
            check(f_f, cur[2]);
            check(f_b, cur[1]);
            check(f_e, cur[0]);
        end
    end
    initial
    begin
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
        for (int t = 0; t < 8; t++)
            send(3'(t), 16'hFFFF, 10'h000, 6'h00, 6'h00);
        send(bcrf_pkg::MSG_RT_TO_RT, 16'hFFFF, 10'h000, 6'h04, 6'h00);
        send(bcrf_pkg::MSG_RT_TO_BC, 16'hFFFF, 10'h000, 6'h02, 6'h00);
        send(bcrf_pkg::MSG_RT_TO_BC, 16'hFFFE, 10'h010, 6'h01, 6'h00);
        send(bcrf_pkg::MSG_RT_TO_BC, 16'hFDFF, 10'h020, 6'h00, 6'h00);
        idle();
        repeat (3) idle();
        for (int i = 0; i < 400; i++)
        begin
            r = lfsr(r);
            q = lfsr(r);
            send(r[28:26], r[25:10], r[9:0], {r[31:29] == 3'h7, q[2:0] == 3'h0,
                q[5:3] == 3'h0, q[8:6] == 3'h0, q[11:9] == 3'h0, q[12]}, q[19:14]);
            r = q;
            if (q[13])
                idle();
            if (i == 200)
            begin
                @(negedge clk_in);
                rst_in = 1'b1;
                // No message may stand at release: it would have no note queued
                msg_done = 1'b0;
                repeat (2) @(negedge clk_in);
                rst_in = 1'b0;
            end
        end
        repeat (3) idle();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire

// ===== include/bcrf_pkg.sv
// Constants shared by the bus controller message result flag logic
`default_nettype none

package bcrf_pkg;

    // ==========================================================
    // Word widths
    localparam int WORD_W = 16;
    localparam int ADDR_W = 6;
    localparam int TYPE_W = 3;

    // ==========================================================
    // Condition register bit positions of the result flags
    localparam int COND_BAD_MESSAGE_BIT = 12;
    localparam int COND_MASKED_STATUS_BIT = 11;
    localparam int COND_GOOD_TRANSFER_BIT = 10;
    localparam int COND_FORMAT_ERROR_BIT = 9;

    // ==========================================================
    // Control word and received status word fields
    localparam int MASK_HI_BIT = 14;
    localparam int MASK_LO_BIT = 9;
    localparam int CW_RESERVED_MASK_BIT = 9;
    localparam int CW_BCR_MASK_BIT = 0;
    localparam int STS_RESERVED_HI_BIT = 7;
    localparam int STS_RESERVED_LO_BIT = 5;
    localparam int STS_BCR_BIT = 4;
    localparam int STS_ADDR_HI_BIT = 15;
    localparam int STS_ADDR_LO_BIT = 10;

    // ==========================================================
    // Controller configuration: broadcast mask enable position
    localparam logic [15:0] CFG_OFFSET = 16'h0032;
    localparam int CFG_BCR_MASK_EN_BIT = 0;

    // ==========================================================
    // Reset values of the flags
    localparam logic FLAG_RESET = 1'h0;

    // ==========================================================
    // Message type codes on msg_type_in
    localparam logic [TYPE_W-1:0] MSG_BC_TO_RT = 3'h0;
    localparam logic [TYPE_W-1:0] MSG_RT_TO_BC = 3'h1;
    localparam logic [TYPE_W-1:0] MSG_RT_TO_RT = 3'h2;
    localparam logic [TYPE_W-1:0] MSG_MODE_TX_DATA = 3'h3;
    localparam logic [TYPE_W-1:0] MSG_MODE_RX_DATA = 3'h4;
    localparam logic [TYPE_W-1:0] MSG_MODE_NO_DATA = 3'h5;

endpackage : bcrf_pkg

`default_nettype wire

// ===== rtl/bcrf_result_flags.sv
// Result flags of the bus controller condition register, updated per message
`default_nettype none

// What this block does
// - Unmasked status bits 14-9 set masked flag
// - Unmasked reserved status bits set masked flag
// - Enabled broadcast bit mismatch sets masked flag
// - Error-free transmit-data messages set good flag
// - Any transmit-side error clears good flag
// - Receive and no-data messages leave good clear
// - Terminal-to-terminal receive fault: error and good
// - Loop-back result never touches good flag
// - Word validation violations set format error
// - Wrong responder address also sets format error
// - Format, loop-back or no-response set bad
module bcrf_result_flags
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic msg_done_in,
    input wire logic [2:0] msg_type_in,
    input wire logic [15:0] control_word_in,
    input wire logic [15:0] status_word_in,
    input wire logic status_valid_in,
    input wire logic [5:0] cmd_addr_in,
    input wire logic bcr_mask_enable_in,
    input wire logic word_error_in,
    input wire logic rx_portion_error_in,
    input wire logic no_response_in,
    input wire logic loopback_fail_in,
    output logic masked_status_flag_out,
    output logic good_transfer_flag_out,
    output logic format_error_flag_out,
    output logic bad_message_flag_out,
    output logic error_flag_out
);

    logic mask_hit;
    logic addr_mismatch;
    logic transmit_kind;
    logic next_masked;
    logic next_good;
    logic next_format;
    logic next_bad;
    logic next_error;

    // ==========================================================
    // Status word evaluation
    bcrf_status_mask u_mask
    (
        .status_word_in(status_word_in),
        .control_word_in(control_word_in),
        .bcr_mask_enable_in(bcr_mask_enable_in),
        .hit_out(mask_hit)
    );

    // Only a status word actually received can carry a wrong address
    assign addr_mismatch = status_valid_in
        & (status_word_in[bcrf_pkg::STS_ADDR_HI_BIT:bcrf_pkg::STS_ADDR_LO_BIT] != cmd_addr_in);

    // ==========================================================
    // Message kinds that move data from a terminal
    function automatic logic is_transmit_kind(input logic [2:0] kind);
        is_transmit_kind = (kind == bcrf_pkg::MSG_RT_TO_BC)
            || (kind == bcrf_pkg::MSG_RT_TO_RT)
            || (kind == bcrf_pkg::MSG_MODE_TX_DATA);
    endfunction : is_transmit_kind

    assign transmit_kind = is_transmit_kind(msg_type_in);

    // ==========================================================
    // Next flag values at message end
    always_comb
    begin
        next_masked = status_valid_in & mask_hit;
        next_format = word_error_in | rx_portion_error_in | addr_mismatch;
        next_bad = next_format | loopback_fail_in | no_response_in;
        next_error = next_bad;
        // Receiving side fault and loop-back are left out on purpose
        next_good = transmit_kind
            & ~word_error_in & ~addr_mismatch & ~no_response_in;
    end

    // ==========================================================
    // Flag registers: host has no write path into them
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            masked_status_flag_out <= bcrf_pkg::FLAG_RESET;
            good_transfer_flag_out <= bcrf_pkg::FLAG_RESET;
            format_error_flag_out <= bcrf_pkg::FLAG_RESET;
            bad_message_flag_out <= bcrf_pkg::FLAG_RESET;
            error_flag_out <= bcrf_pkg::FLAG_RESET;
        end
        else if (msg_done_in)
        begin
            masked_status_flag_out <= next_masked;
            good_transfer_flag_out <= next_good;
            format_error_flag_out <= next_format;
            bad_message_flag_out <= next_bad;
            error_flag_out <= next_error;
        end
    end

    // ==========================================================
    // Checks
    a_mask_bits_set: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && status_valid_in
        && (|(status_word_in[bcrf_pkg::MASK_HI_BIT:bcrf_pkg::MASK_LO_BIT]
        & ~control_word_in[bcrf_pkg::MASK_HI_BIT:bcrf_pkg::MASK_LO_BIT]))
        |=> masked_status_flag_out)
        else $error("unmasked status bit did not set masked flag");

    a_reserved_set: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && status_valid_in && !control_word_in[bcrf_pkg::CW_RESERVED_MASK_BIT]
        && (|status_word_in[bcrf_pkg::STS_RESERVED_HI_BIT:bcrf_pkg::STS_RESERVED_LO_BIT])
        |=> masked_status_flag_out)
        else $error("reserved status bit did not set masked flag");

    a_bcr_mismatch: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && status_valid_in && bcr_mask_enable_in
        && (control_word_in[bcrf_pkg::CW_BCR_MASK_BIT] != status_word_in[bcrf_pkg::STS_BCR_BIT])
        |=> masked_status_flag_out)
        else $error("broadcast mismatch did not set masked flag");

    a_mask_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && status_valid_in && !bcr_mask_enable_in
        && !(|(status_word_in[bcrf_pkg::MASK_HI_BIT:bcrf_pkg::MASK_LO_BIT]
        & ~control_word_in[bcrf_pkg::MASK_HI_BIT:bcrf_pkg::MASK_LO_BIT]))
        && (control_word_in[bcrf_pkg::CW_RESERVED_MASK_BIT]
        || !(|status_word_in[bcrf_pkg::STS_RESERVED_HI_BIT:bcrf_pkg::STS_RESERVED_LO_BIT]))
        |=> !masked_status_flag_out)
        else $error("masked flag set with all status bits masked");

    a_good_set: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && is_transmit_kind(msg_type_in)
        && !word_error_in && !no_response_in && !addr_mismatch
        |=> good_transfer_flag_out)
        else $error("error-free transmit message did not set good flag");

    a_good_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && (word_error_in || no_response_in || addr_mismatch)
        |=> !good_transfer_flag_out && bad_message_flag_out)
        else $error("good flag survived a message error");

    a_good_kinds: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && (msg_type_in == bcrf_pkg::MSG_BC_TO_RT
        || msg_type_in == bcrf_pkg::MSG_MODE_RX_DATA
        || msg_type_in == bcrf_pkg::MSG_MODE_NO_DATA)
        |=> !good_transfer_flag_out)
        else $error("good flag set for a receive or no-data message");

    a_rtrt_both: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && msg_type_in == bcrf_pkg::MSG_RT_TO_RT && rx_portion_error_in
        && !word_error_in && !no_response_in && !addr_mismatch
        |=> good_transfer_flag_out && error_flag_out)
        else $error("receiving fault did not show both error and good");

    a_loop_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && loopback_fail_in && is_transmit_kind(msg_type_in)
        && !word_error_in && !no_response_in && !addr_mismatch
        |=> good_transfer_flag_out && bad_message_flag_out)
        else $error("loop-back failure changed the good flag");

    a_format_set: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in |=> format_error_flag_out == $past(word_error_in | rx_portion_error_in
        | addr_mismatch))
        else $error("format flag does not follow validation result");

    a_addr_format: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && status_valid_in
        && (status_word_in[bcrf_pkg::STS_ADDR_HI_BIT:bcrf_pkg::STS_ADDR_LO_BIT] != cmd_addr_in)
        |=> format_error_flag_out && !good_transfer_flag_out)
        else $error("wrong responder address not flagged");

    a_bad_message: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in |=> bad_message_flag_out
        == ($past(loopback_fail_in) || $past(no_response_in) || format_error_flag_out))
        else $error("bad message flag wrong");

    a_flags_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !msg_done_in |=> $stable({masked_status_flag_out, good_transfer_flag_out,
        format_error_flag_out, bad_message_flag_out, error_flag_out}))
        else $error("flags changed without a message end");

    a_reset_clear: assert property (@(posedge clk_in)
        rst_in |=> !masked_status_flag_out && !good_transfer_flag_out
        && !format_error_flag_out && !bad_message_flag_out && !error_flag_out)
        else $error("flags not cleared by reset");

    // A message without a status word must not leave a stale masked result
    a_status_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && !status_valid_in
        |=> !masked_status_flag_out)
        else $error("masked flag set without a status word");

    a_rx_format: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && rx_portion_error_in
        |=> format_error_flag_out && error_flag_out)
        else $error("receiving fault did not raise the error flags");

    a_noresp_bad: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && no_response_in
        |=> bad_message_flag_out && !good_transfer_flag_out)
        else $error("missing response not reported as bad");

    a_loop_bad: assert property (@(posedge clk_in) disable iff (rst_in)
        msg_done_in && loopback_fail_in
        |=> bad_message_flag_out && error_flag_out)
        else $error("loop-back failure not reported as bad");

    a_error_bad: assert property (@(posedge clk_in) disable iff (rst_in)
        error_flag_out == bad_message_flag_out)
        else $error("error flag differs from bad message flag");

    // First cycle after release with no message must keep the cleared flags
    a_release_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(rst_in) && !msg_done_in
        |=> !masked_status_flag_out && !good_transfer_flag_out
        && !format_error_flag_out && !bad_message_flag_out)
        else $error("flags changed right after reset release");

endmodule : bcrf_result_flags

`default_nettype wire

// ===== rtl/bcrf_status_mask.sv
// Masked status evaluation of one received status word
`default_nettype none

module bcrf_status_mask
(
    input wire logic [15:0] status_word_in,
    input wire logic [15:0] control_word_in,
    input wire logic bcr_mask_enable_in,
    output logic hit_out
);

    logic [bcrf_pkg::MASK_HI_BIT:bcrf_pkg::MASK_LO_BIT] unmasked;
    logic reserved_hit;
    logic bcr_hit;

    // ==========================================================
    // Status bits that the control word leaves unmasked
    genvar i;
    generate
        for (i = bcrf_pkg::MASK_LO_BIT; i <= bcrf_pkg::MASK_HI_BIT; i++)
        begin : g_mask
            assign unmasked[i] = status_word_in[i] & ~control_word_in[i];
        end
    endgenerate

    assign reserved_hit = ~control_word_in[bcrf_pkg::CW_RESERVED_MASK_BIT]
        & (|status_word_in[bcrf_pkg::STS_RESERVED_HI_BIT:bcrf_pkg::STS_RESERVED_LO_BIT]);

    // Mismatch of the two broadcast bits only counts when enabled
    assign bcr_hit = bcr_mask_enable_in
        & (control_word_in[bcrf_pkg::CW_BCR_MASK_BIT] ^ status_word_in[bcrf_pkg::STS_BCR_BIT]);

    assign hit_out = (|unmasked) | reserved_hit | bcr_hit;

endmodule : bcrf_status_mask

`default_nettype wire
